//--- sapc_host_model.sv
// host side model: comparator answers and resolved result bus
`timescale 1ns/1ps
module sapc_host_model (
  input  wire logic        clk,
  input  wire logic        hold,
  input  wire logic [11:0] target,
  input  wire logic [11:0] data_out,
  input  wire logic [11:0] data_oe,
  output logic             comp_hi,
  output logic [11:0]      bus
);
  logic [11:0] last = 12'h000;
  logic [11:0] trial_bits;

  // ------------------------------------------------------------
  // comparator and bus resolution
  // ------------------------------------------------------------
  // held input sits inside the target code: the comparator keeps exactly the target's bits,
  // msb first, one per clock while held; this only fits a bench bit time of one cycle
  always_ff @(posedge clk) begin
    if (!hold) begin
      trial_bits <= target;
    end else begin
      trial_bits <= {trial_bits[10:0], 1'b0};
    end
  end
  assign comp_hi = trial_bits[11];
  // a floating line shows the inverse of its last value, never a stale match
  assign bus = (data_out & data_oe) | (~last & ~data_oe);
  // remember the resolved lines for the next cycle
  always_ff @(posedge clk) begin
    last <= bus;
  end
endmodule

//--- sapc_map.svh
// codes, widths and timing counts for the converter port control
`ifndef SAPC_MAP_SVH
`define SAPC_MAP_SVH
`define SAPC_RES_W        12
`define SAPC_CLK_MHZ      25
`define SAPC_BIT_NS       400
`define SAPC_BIT_CYC      ((`SAPC_BIT_NS * `SAPC_CLK_MHZ + 999) / 1000)
`define SAPC_ACQ_NS       1000
`define SAPC_ACQ_CYC      ((`SAPC_ACQ_NS * `SAPC_CLK_MHZ + 999) / 1000)
`define SAPC_BITS_LONG    12
`define SAPC_BITS_SHORT   8
`define SAPC_MID_LOW      12'h7FF
`define SAPC_MID_HIGH     12'h800
`define SAPC_TOP_CODE     12'hFFF
`endif

//--- sapc_pkg.sv
// shared types for the converter port control
package sapc_pkg;
  typedef enum logic [1:0] {
    SAPC_IDLE = 2'b00,
    SAPC_CONV = 2'b01,
    SAPC_ACQ  = 2'b10
  } sapc_state_e;
  typedef struct packed {
    logic [11:0] data;
    logic [11:0] oe;
  } sapc_bus_s;
endpackage

//--- sapc_sar.sv
// successive-approximation bit sequencer, msb first
`timescale 1ns/1ps
`include "sapc_map.svh"
module sapc_sar #(
  parameter int W = 12
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         start,
  input  wire logic         short_cyc,
  input  wire logic         step,
  input  wire logic         comp_hi,
  output logic              done,
  output logic [W-1:0]      code
);
  logic [W-1:0] trial;
  logic [W-1:0] stop_bit;

  // -----------------------------
  // trial bit walk
  // -----------------------------
  // short cycle stops after the eighth bit; lower bits stay zero
  assign stop_bit = short_cyc ? W'(1 << (W - `SAPC_BITS_SHORT)) : W'(1);
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      trial <= '0;
      code  <= '0;
      done  <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start) begin
        trial <= W'(1 << (W - 1));
        code  <= W'(1 << (W - 1));
      end else if (step && trial != '0) begin
        // keep the bit while the dac sum stays below the input
        code <= (comp_hi ? code : (code & ~trial)) | ((trial == stop_bit) ? '0 : (trial >> 1));
        trial <= (trial == stop_bit) ? '0 : (trial >> 1);
        done  <= (trial == stop_bit);
      end
    end
  end
endmodule

//--- sapc_top.sv
// converter control and three-state result port
`timescale 1ns/1ps
`include "sapc_map.svh"
module sapc_top #(
  parameter int BIT_CYC = `SAPC_BIT_CYC,
  parameter int ACQ_CYC = `SAPC_ACQ_CYC
) (
  input  wire logic        CLK,
  input  wire logic        RST_N,
  input  wire logic        CHIP_EN,
  input  wire logic        CHIP_SEL_N,
  input  wire logic        READ_CONVERT,
  input  wire logic        WORD_WIDTH_SEL,
  input  wire logic        BYTE_SELECT_SHORT_CYCLE,
  input  wire logic        COMP_HI,
  output logic             CONVERSION_BUSY_FLAG,
  output logic             SAMPLE_HOLD,
  output logic [11:0]      DATA_OUT,
  output logic [11:0]      DATA_OE
);
  // -----------------------------
  // pin synchronisers
  // -----------------------------
  logic [4:0] s1, s2;
  logic       rc_q;
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      s1   <= 5'h00;
      s2   <= 5'h00;
      rc_q <= 1'b0;
    end else begin
      s1   <= {CHIP_EN, ~CHIP_SEL_N, READ_CONVERT, WORD_WIDTH_SEL, BYTE_SELECT_SHORT_CYCLE};
      s2   <= s1;
      rc_q <= s2[2];
    end
  end
  logic en, rc, wsel, bsel, sel_ok, fall;
  assign en     = s2[4];
  assign sel_ok = s2[3];
  assign rc     = s2[2];
  assign wsel   = s2[1];
  assign bsel   = s2[0];
  assign fall   = rc_q & ~rc;

  // -----------------------------
  // conversion sequencing
  // -----------------------------
  sapc_pkg::sapc_state_e state;
  logic        start, step, done, short_q;
  logic [11:0] code, result;
  logic [15:0] cnt;
  // a level low, or a fresh falling edge, while enabled starts a conversion
  assign start = (state == sapc_pkg::SAPC_IDLE) && en && sel_ok && (!rc || fall);
  assign step  = (state == sapc_pkg::SAPC_CONV) && (cnt == 16'(BIT_CYC - 1));

  sapc_sar #(.W(`SAPC_RES_W)) u_sar (
    .clk       (CLK),
    .rst_n     (RST_N),
    .start     (start),
    .short_cyc (short_q), // length latched at the start, not the live pin
    .step      (step),
    .comp_hi   (COMP_HI),
    .done      (done),
    .code      (code)
  );

  // start commands are ignored until the cycle, acquisition included, ends
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      state   <= sapc_pkg::SAPC_IDLE;
      cnt     <= 16'h0000;
      short_q <= 1'b0;
      result  <= 12'h000;
    end else begin
      unique case (state)
        sapc_pkg::SAPC_IDLE: begin
          cnt <= 16'h0000;
          if (start) begin
            state   <= sapc_pkg::SAPC_CONV;
            short_q <= bsel;
          end
        end
        sapc_pkg::SAPC_CONV: begin
          // restart on done too, so acquisition always opens at zero and lasts ACQ_CYC
          cnt <= (step || done) ? 16'h0000 : cnt + 16'h0001;
          if (done) begin
            state  <= sapc_pkg::SAPC_ACQ;
            result <= code; // plain binary, every code possible on a long cycle; a short cycle leaves bits 3:0 at zero
          end
        end
        sapc_pkg::SAPC_ACQ: begin
          cnt <= cnt + 16'h0001;
          if (cnt == 16'(ACQ_CYC - 1)) begin
            state <= sapc_pkg::SAPC_IDLE;
          end
        end
        default: state <= sapc_pkg::SAPC_IDLE;
      endcase
    end
  end

  // busy while converting or acquiring
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      CONVERSION_BUSY_FLAG <= 1'b0;
      SAMPLE_HOLD          <= 1'b0;
    end else begin
      CONVERSION_BUSY_FLAG <= start || (state == sapc_pkg::SAPC_CONV) ||
                              (state == sapc_pkg::SAPC_ACQ && cnt != 16'(ACQ_CYC - 1));
      SAMPLE_HOLD          <= start || (state == sapc_pkg::SAPC_CONV && !done);
    end
  end

  // -----------------------------
  // output organisation
  // -----------------------------
  function automatic sapc_pkg::sapc_bus_s org(input logic [11:0] r, input logic w, input logic b);
    sapc_pkg::sapc_bus_s o;
    o.data = r;
    o.oe   = 12'hFFF;
    if (!w) begin // two byte reads
      if (b) begin
        o.data = {4'h0, 4'h0, r[3:0]};
        o.oe   = 12'h0FF;
      end else begin
        o.data = {r[11:4], 4'h0};
        o.oe   = 12'hFF0;
      end
    end
    return o; // word mode drives all twelve
  endfunction

  logic rd_ok;
  sapc_pkg::sapc_bus_s bus;
  assign rd_ok = en && sel_ok && rc && (state != sapc_pkg::SAPC_CONV) && !start;
  assign bus   = org(result, wsel, bsel);
  // lines float whenever no enabled read is under way
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      DATA_OUT <= 12'h000;
      DATA_OE  <= 12'h000;
    end else begin
      DATA_OUT <= rd_ok ? bus.data : 12'h000;
      DATA_OE  <= rd_ok ? bus.oe : 12'h000;
    end
  end

  // -----------------------------
  // checks
  // -----------------------------
  sequence conv_start_s;
    start;
  endsequence
  busy_on_start_a: assert property (@(posedge CLK) disable iff (!RST_N)
    conv_start_s |=> CONVERSION_BUSY_FLAG) else $error("busy not raised");
  no_drive_conv_a: assert property (@(posedge CLK) disable iff (!RST_N)
    state == sapc_pkg::SAPC_CONV |=> DATA_OE == 12'h000) else $error("driven in conversion");
  idle_float_a: assert property (@(posedge CLK) disable iff (!RST_N)
    !(en && sel_ok) |=> DATA_OE == 12'h000) else $error("driven when deselected");
  byte_hi_a: assert property (@(posedge CLK) disable iff (!RST_N)
    rd_ok && !wsel && bsel |=> DATA_OE == 12'h0FF && DATA_OUT[7:4] == 4'h0) else $error("low byte");
  byte_lo_a: assert property (@(posedge CLK) disable iff (!RST_N)
    rd_ok && !wsel && !bsel |=> DATA_OE == 12'hFF0) else $error("high byte");
  word_read_a: assert property (@(posedge CLK) disable iff (!RST_N)
    rd_ok && wsel |=> DATA_OE == 12'hFFF && DATA_OUT == $past(result)) else $error("word");
  short_len_a: assert property (@(posedge CLK) disable iff (!RST_N)
    done && short_q |=> result[3:0] == 4'h0) else $error("short tail");
  busy_drop_a: assert property (@(posedge CLK) disable iff (!RST_N)
    state == sapc_pkg::SAPC_IDLE && !start |=> !CONVERSION_BUSY_FLAG) else $error("busy stuck");

  // -----------------------------
  // cycle length and per-state checks
  // -----------------------------
  // last conversion cycle counted from the start cycle: every bit takes BIT_CYC
  // cycles and done arrives one cycle after the final step
  localparam int LONG_LAST  = `SAPC_BITS_LONG * BIT_CYC + 1;
  localparam int SHORT_LAST = `SAPC_BITS_SHORT * BIT_CYC + 1;
  localparam int ACQ_LAST   = ACQ_CYC - 1;

  // the length is chosen by the select level seen in the start cycle
  sequence long_start_s;
    start && !bsel;
  endsequence
  sequence short_start_s;
    start && bsel;
  endsequence
  sequence conv_end_s;
    state == sapc_pkg::SAPC_CONV ##1 state == sapc_pkg::SAPC_ACQ;
  endsequence

  long_len_a: assert property (@(posedge CLK) disable iff (!RST_N)
    long_start_s |-> ##LONG_LAST conv_end_s) else $error("long conversion length");
  short_cycle_a: assert property (@(posedge CLK) disable iff (!RST_N)
    short_start_s |-> ##SHORT_LAST conv_end_s) else $error("short conversion length");
  acq_len_a: assert property (@(posedge CLK) disable iff (!RST_N)
    conv_end_s |-> ##ACQ_LAST state == sapc_pkg::SAPC_ACQ ##1 state == sapc_pkg::SAPC_IDLE) else $error("acq length");
  conv_busy_a: assert property (@(posedge CLK) disable iff (!RST_N)
    state == sapc_pkg::SAPC_CONV |-> CONVERSION_BUSY_FLAG && SAMPLE_HOLD) else $error("busy or hold low");
  acq_release_a: assert property (@(posedge CLK) disable iff (!RST_N)
    state == sapc_pkg::SAPC_ACQ |-> !SAMPLE_HOLD) else $error("hold kept in acquisition");
  acq_read_a: assert property (@(posedge CLK) disable iff (!RST_N)
    state == sapc_pkg::SAPC_ACQ && en && sel_ok && rc |=> DATA_OE != 12'h000) else $error("acq read refused");
  acq_end_a: assert property (@(posedge CLK) disable iff (!RST_N)
    state == sapc_pkg::SAPC_ACQ && cnt == 16'(ACQ_CYC - 1) |=> !CONVERSION_BUSY_FLAG) else $error("busy late");
  deselect_idle_a: assert property (@(posedge CLK) disable iff (!RST_N)
    state == sapc_pkg::SAPC_IDLE && !(en && sel_ok) |=> state == sapc_pkg::SAPC_IDLE) else $error("stray start");
endmodule

//--- sapc_top_tb.sv
// self-checking bench for the converter port control
`timescale 1ns/1ps
module sapc_top_tb;
  logic        CLK = 1'b0;
  logic        RST_N = 1'b0;
  logic        CHIP_EN = 1'b1;
  logic        CHIP_SEL_N = 1'b0;
  logic        READ_CONVERT = 1'b1;
  logic        WORD_WIDTH_SEL = 1'b1;
  logic        BYTE_SELECT_SHORT_CYCLE = 1'b0;
  logic [11:0] target = 12'h000;
  logic        SAMPLE_HOLD;
  logic        COMP_HI;
  logic        CONVERSION_BUSY_FLAG;
  logic [11:0] DATA_OUT;
  logic [11:0] DATA_OE;
  logic [11:0] bus;
  int          bad_count = 0;
  int          cmp_count = 0;

  // short bit and acquisition counts keep the run brief
  sapc_top #(.BIT_CYC(1), .ACQ_CYC(2)) dut (.CLK(CLK), .RST_N(RST_N), .CHIP_EN(CHIP_EN),
    .CHIP_SEL_N(CHIP_SEL_N), .READ_CONVERT(READ_CONVERT), .WORD_WIDTH_SEL(WORD_WIDTH_SEL),
    .BYTE_SELECT_SHORT_CYCLE(BYTE_SELECT_SHORT_CYCLE), .COMP_HI(COMP_HI),
    .CONVERSION_BUSY_FLAG(CONVERSION_BUSY_FLAG), .SAMPLE_HOLD(SAMPLE_HOLD), .DATA_OUT(DATA_OUT), .DATA_OE(DATA_OE));
  sapc_host_model host (.clk(CLK), .hold(SAMPLE_HOLD), .target(target), .data_out(DATA_OUT),
    .data_oe(DATA_OE), .comp_hi(COMP_HI), .bus(bus));

  // 25 MHz clock
  always #20 CLK = ~CLK;

  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task automatic chk(input string what, input logic [11:0] exp, input logic [11:0] got);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  // falling read/convert pulse; the comparator model steers the result to code
  task automatic conv(input logic sc, input logic [11:0] code);
    int n;
    @(posedge CLK);
    target <= code;
    BYTE_SELECT_SHORT_CYCLE <= sc;
    READ_CONVERT <= 1'b0;
    repeat (2) @(posedge CLK);
    READ_CONVERT <= 1'b1;
    n = 0;
    while (CONVERSION_BUSY_FLAG !== 1'b1 && n < 10) begin
      @(negedge CLK);
      n++;
    end
    chk("busy", 12'h001, {11'h000, CONVERSION_BUSY_FLAG});
    chk("hold", 12'h001, {11'h000, SAMPLE_HOLD});
    // length is fixed at the start; flipping the select mid-conversion must not alter it
    @(posedge CLK);
    BYTE_SELECT_SHORT_CYCLE <= ~sc;
    @(negedge CLK);
    chk("oe while busy", 12'h000, DATA_OE);
    n = 0;
    while (CONVERSION_BUSY_FLAG === 1'b1 && n < 200) begin
      @(negedge CLK);
      n++;
    end
    chk("busy end", 12'h000, {11'h000, CONVERSION_BUSY_FLAG});
    chk("hold end", 12'h000, {11'h000, SAMPLE_HOLD});
  endtask

  // read with the given organisation; sync plus register delay is settled after four cycles
  task automatic rd(input logic ww, input logic bs, input logic [11:0] exp, input logic [11:0] oe);
    @(posedge CLK);
    WORD_WIDTH_SEL <= ww;
    BYTE_SELECT_SHORT_CYCLE <= bs;
    repeat (4) @(negedge CLK);
    chk("oe", oe, DATA_OE);
    chk("lines", exp & oe, bus & oe);
  endtask

  task automatic test_done;
    if (bad_count == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    repeat (8) @(posedge CLK);
    RST_N <= 1'b1;
    // not enabled or not selected: no read and no conversion
    for (int i = 0; i < 2; i++) begin
      @(posedge CLK);
      CHIP_EN <= i[0];
      CHIP_SEL_N <= i[0];
      rd(1'b1, 1'b0, 12'h000, 12'h000);
      @(posedge CLK);
      READ_CONVERT <= 1'b0;
      repeat (6) @(negedge CLK);
      chk("busy off", 12'h000, {11'h000, CONVERSION_BUSY_FLAG});
      @(posedge CLK);
      READ_CONVERT <= 1'b1;
    end
    @(posedge CLK);
    CHIP_EN <= 1'b1;
    CHIP_SEL_N <= 1'b0;
    conv(1'b0, 12'hA5C);
    rd(1'b1, 1'b0, 12'hA5C, 12'hFFF);
    rd(1'b0, 1'b0, 12'hA50, 12'hFF0);
    rd(1'b0, 1'b1, 12'h00C, 12'h0FF);
    conv(1'b1, 12'hA5C);
    rd(1'b1, 1'b0, 12'hA50, 12'hFFF);
    // codes either side of mid scale and at both the top and the bottom end
    conv(1'b0, 12'h7FF);
    rd(1'b1, 1'b0, 12'h7FF, 12'hFFF);
    conv(1'b0, 12'h800);
    rd(1'b1, 1'b0, 12'h800, 12'hFFF);
    conv(1'b0, 12'hFFE);
    rd(1'b1, 1'b0, 12'hFFE, 12'hFFF);
    conv(1'b0, 12'hFFF);
    rd(1'b1, 1'b0, 12'hFFF, 12'hFFF);
    conv(1'b0, 12'h000);
    rd(1'b1, 1'b0, 12'h000, 12'hFFF);
    test_done;
  end

  // watchdog: the sequence needs well under a thousand cycles
  initial begin
    #200000;
    bad_count++;
    test_done;
  end
endmodule
